// *** hw/repg_pkg.sv ***
// Purpose: constants for the rail enable override and power-good delay block
// Assumes: 100 MHz REF_CLK, 8-bit register port with byte offsets
// Notes: factory defaults are parameters of the top module
//
// Functional notes
// - gp_output_3 asserts power good only after its delay, counted once all its grouped rails regulate.
// - a delayed output may instead be factory-set as system power good, level shifter or software output.
// - gp2_pg_delay in bits 7:5 picks 2.5, 5, 10, 15, 20, 50, 50 or 100 ms for gp_output_2.
// - gp4_pg_delay in bits 4:2 picks the delay for gp_output_4 with the same eight-value table.
// - gp1_pg_delay in bits 1:0 picks 0, 5, 10 or 15 ms for gp_output_1.
// - every delay lies within ten percent of nominal, so the timebase may carry that error.
// - load switch b2, b1 and a1 disable bits at 7, 6, 5 force their switch off when 0.
// - the termination regulator disable bit at 4 forces that regulator off when 0.
// - step-down rails 1 to 6 force-on bits 0 to 5 force the rail on unless disabled, else pin control.
// - load switch a1 force-on bit 6 forces it on unless disabled, else pin control.
// - linear regulator a2 force-on bit 7 forces it on unless disabled, else pin control.
// - step-down rails 1 to 3 disable bits force the rail off when 0.
package repg_pkg;
    localparam logic [7:0] ADDR_PG_DELAY = 8'h9d;
    localparam logic [7:0] ADDR_SW_DIS = 8'h9f;
    localparam logic [7:0] ADDR_FORCE_EN = 8'ha0;
    localparam int GP2_LSB = 5;
    localparam int GP4_LSB = 2;
    localparam int GP1_LSB = 0;
    localparam int SW_B2_BIT = 7;
    localparam int SW_B1_BIT = 6;
    localparam int SW_A1_BIT = 5;
    localparam int TERM_BIT = 4;
    localparam logic [7:0] SW_DIS_WMASK = 8'hf0;
    localparam int LINEAR_REG_A2_FBIT = 7;
    localparam int LOAD_SWITCH_A1_FBIT = 6;
    localparam int NUM_RAILS = 12;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 100;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [7:0] DLY_2P5_TICKS = 8'h19;
    localparam logic [7:0] DLY_5_TICKS = 8'h32;
    localparam logic [7:0] DLY_10_TICKS = 8'h64;
    localparam logic [7:0] DLY_15_TICKS = 8'h96;
    localparam logic [7:0] DLY_20_TICKS = 8'hc8;
    localparam logic [7:0] DLY_0_TICKS = 8'h00;
    localparam logic [15:0] DLY_50_TICKS = 16'h01f4;
    localparam logic [15:0] DLY_100_TICKS = 16'h03e8;
    typedef enum logic [1:0] {GPO_DELAYED_PG, GPO_SYSTEM_PG, GPO_LEVEL_SHIFT, GPO_SOFTWARE} repg_mode_e;
endpackage : repg_pkg

// *** hw/repg_pg_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Purpose: carries one delay request and its timebase into a power-good channel
// Assumes: one clock domain
// Notes: driven by the top, read by repg_pg_delay
interface repg_pg_if;
    logic tick;
    logic [15:0] delay_ticks;
    logic all_good;
    logic pg_out;
    modport src (output tick, output delay_ticks, output all_good, input pg_out);
    modport chan (input tick, input delay_ticks, input all_good, output pg_out);
endinterface : repg_pg_if
`default_nettype wire

// *** hw/repg_pg_delay.sv ***
`timescale 1ns/10ps
`default_nettype none
// Purpose: one power-good delay channel
// Assumes: tick is a one-cycle pulse every 100 us
// Notes: tick phase adds up to one tick of error, within tolerance
module repg_pg_delay (
    input wire logic clk,
    input wire logic rst,
    repg_pg_if.chan p
);
    logic [15:0] cnt_q, cnt_d;
    logic pg_q, pg_d;

    always_comb begin
        cnt_d = cnt_q;
        pg_d = pg_q;
        if (!p.all_good) begin
            cnt_d = '0;
            pg_d = 1'b0;
        end else if (!pg_q) begin
            if (cnt_q >= p.delay_ticks) begin
                pg_d = 1'b1;
            end else if (p.tick) begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            pg_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pg_q <= pg_d;
        end
    end

    assign p.pg_out = pg_q;
endmodule : repg_pg_delay
`default_nettype wire

// *** hw/repg_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Purpose: rail enable override and programmable power-good delays
// Assumes: register port is a one-cycle strobe decoded from the serial management port
// Notes: rails 0-5 step-down 1-6, 6 load switch a1, 7 linear reg a2, 8 b1, 9 b2, 10 termination, 11 spare
module repg_top #(
    parameter logic [7:0] PG_DELAY_DEF = 8'h12,
    parameter logic [7:0] SW_DIS_DEF = 8'hf0,
    parameter logic [7:0] FORCE_EN_DEF = 8'h00,
    parameter logic [2:0] STEP_DIS_DEF = 3'h7,
    parameter logic [3:0] GP1_GROUP = 4'h1,
    parameter logic [3:0] GP2_GROUP = 4'h2,
    parameter logic [3:0] GP3_GROUP = 4'h4,
    parameter logic [3:0] GP4_GROUP = 4'h8,
    parameter logic [15:0] GP3_DELAY_TICKS = 16'h0032,
    parameter int TICK_CYCLES = repg_pkg::TICK_CYC,
    parameter repg_pkg::repg_mode_e GP1_MODE = repg_pkg::GPO_DELAYED_PG,
    parameter repg_pkg::repg_mode_e GP2_MODE = repg_pkg::GPO_DELAYED_PG,
    parameter repg_pkg::repg_mode_e GP3_MODE = repg_pkg::GPO_DELAYED_PG,
    parameter repg_pkg::repg_mode_e GP4_MODE = repg_pkg::GPO_DELAYED_PG
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_ACK,
    input wire logic [2:0] STEP_DIS,
    input wire logic [repg_pkg::NUM_RAILS-1:0] SEQ_EN,
    input wire logic [3:0] RAIL_IN_REG,
    input wire logic [3:0] GP_LEVEL,
    input wire logic [3:0] GP_LS_IN,
    output logic [repg_pkg::NUM_RAILS-1:0] RAIL_EN,
    output logic [3:0] GP_OUT
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] pg_dly_q, pg_dly_d;
    logic [7:0] sw_dis_q, sw_dis_d;
    logic [7:0] force_q, force_d;
    logic [7:0] rdata_q, rdata_d;
    logic ack_q, ack_d;

    always_comb begin
        pg_dly_d = pg_dly_q;
        sw_dis_d = sw_dis_q;
        force_d = force_q;
        rdata_d = rdata_q;
        ack_d = REG_WR | REG_RD;
        if (REG_WR) begin
            unique case (REG_ADDR)
                repg_pkg::ADDR_PG_DELAY: pg_dly_d = REG_WDATA;
                // reserved bits held at zero even if software misbehaves
                repg_pkg::ADDR_SW_DIS: sw_dis_d = REG_WDATA & repg_pkg::SW_DIS_WMASK;
                repg_pkg::ADDR_FORCE_EN: force_d = REG_WDATA;
                default: ;
            endcase
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                repg_pkg::ADDR_PG_DELAY: rdata_d = pg_dly_q;
                repg_pkg::ADDR_SW_DIS: rdata_d = sw_dis_q;
                repg_pkg::ADDR_FORCE_EN: rdata_d = force_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pg_dly_q <= PG_DELAY_DEF;
            sw_dis_q <= SW_DIS_DEF;
            force_q <= FORCE_EN_DEF;
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
        end else begin
            pg_dly_q <= pg_dly_d;
            sw_dis_q <= sw_dis_d;
            force_q <= force_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_ACK = ack_q;

    // ************************************************************
    // rail enables
    // ************************************************************
    logic [repg_pkg::NUM_RAILS-1:0] allow, force_on, en_d, en_q;

    always_comb begin
        allow = '1;
        allow[2:0] = STEP_DIS;
        allow[6] = sw_dis_q[repg_pkg::SW_A1_BIT];
        allow[8] = sw_dis_q[repg_pkg::SW_B1_BIT];
        allow[9] = sw_dis_q[repg_pkg::SW_B2_BIT];
        allow[10] = sw_dis_q[repg_pkg::TERM_BIT];
        force_on = '0;
        force_on[5:0] = force_q[5:0];
        force_on[6] = force_q[repg_pkg::LOAD_SWITCH_A1_FBIT];
        force_on[7] = force_q[repg_pkg::LINEAR_REG_A2_FBIT];
        en_d = allow & (force_on | SEQ_EN);
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            en_q <= '0;
        end else begin
            en_q <= en_d;
        end
    end

    assign RAIL_EN = en_q;

    // ************************************************************
    // 100 us timebase
    // ************************************************************
    logic [15:0] div_q, div_d;
    logic tick_q, tick_d;

    always_comb begin
        tick_d = (div_q == 16'(TICK_CYCLES - 1));
        div_d = tick_d ? 16'h0000 : div_q + 16'h0001;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // ************************************************************
    // delay decode and power-good channels
    // ************************************************************
    function automatic logic [15:0] dly3(input logic [2:0] c);
        logic [15:0] r;
        r = repg_pkg::DLY_100_TICKS;
        unique case (c)
            3'h0: r = {8'h00, repg_pkg::DLY_2P5_TICKS};
            3'h1: r = {8'h00, repg_pkg::DLY_5_TICKS};
            3'h2: r = {8'h00, repg_pkg::DLY_10_TICKS};
            3'h3: r = {8'h00, repg_pkg::DLY_15_TICKS};
            3'h4: r = {8'h00, repg_pkg::DLY_20_TICKS};
            3'h5, 3'h6: r = repg_pkg::DLY_50_TICKS;
            3'h7: r = repg_pkg::DLY_100_TICKS;
        endcase
        return r;
    endfunction : dly3

    function automatic logic [15:0] dly2(input logic [1:0] c);
        logic [15:0] r;
        r = 16'h0000;
        unique case (c)
            2'h0: r = {8'h00, repg_pkg::DLY_0_TICKS};
            2'h1: r = {8'h00, repg_pkg::DLY_5_TICKS};
            2'h2: r = {8'h00, repg_pkg::DLY_10_TICKS};
            2'h3: r = {8'h00, repg_pkg::DLY_15_TICKS};
        endcase
        return r;
    endfunction : dly2

    logic [15:0] dly [4];
    logic [3:0] grp [4];
    repg_pkg::repg_mode_e mode [4];
    logic [3:0] pg, gp_d, gp_q;
    logic [3:0] sys_good;

    assign dly[0] = dly2(pg_dly_q[repg_pkg::GP1_LSB +: 2]);
    assign dly[1] = dly3(pg_dly_q[repg_pkg::GP2_LSB +: 3]);
    assign dly[2] = GP3_DELAY_TICKS;
    assign dly[3] = dly3(pg_dly_q[repg_pkg::GP4_LSB +: 3]);
    assign grp[0] = GP1_GROUP;
    assign grp[1] = GP2_GROUP;
    assign grp[2] = GP3_GROUP;
    assign grp[3] = GP4_GROUP;
    assign mode[0] = GP1_MODE;
    assign mode[1] = GP2_MODE;
    assign mode[2] = GP3_MODE;
    assign mode[3] = GP4_MODE;
    assign sys_good = {4{&RAIL_IN_REG}};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_gp
            repg_pg_if pif ();
            assign pif.tick = tick_q;
            assign pif.delay_ticks = dly[g];
            assign pif.all_good = &(RAIL_IN_REG | ~grp[g]);
            assign pg[g] = pif.pg_out;
            repg_pg_delay u_dly (
                .clk(REF_CLK),
                .rst(RST),
                .p(pif)
            );
            always_comb begin
                unique case (mode[g])
                    repg_pkg::GPO_DELAYED_PG: gp_d[g] = pg[g];
                    repg_pkg::GPO_SYSTEM_PG: gp_d[g] = sys_good[g];
                    repg_pkg::GPO_LEVEL_SHIFT: gp_d[g] = GP_LS_IN[g];
                    repg_pkg::GPO_SOFTWARE: gp_d[g] = GP_LEVEL[g];
                endcase
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            gp_q <= '0;
        end else begin
            gp_q <= gp_d;
        end
    end

    assign GP_OUT = gp_q;
endmodule : repg_top
`default_nettype wire

// *** verif/repg_props.sv ***
// Purpose: port assertions for repg_top
// Assumes: one clock, RST async high
// Notes: gp_output_3 grouped to bit 2
`timescale 1ns/10ps
`default_nettype none
module repg_props #(
    parameter logic [15:0] GP3_DELAY_TICKS = 16'h0032,
    parameter int TICK_CYCLES = repg_pkg::TICK_CYC,
    parameter logic [3:0] DLY_MASK = 4'hf
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_ACK,
    input wire logic [2:0] STEP_DIS,
    input wire logic [repg_pkg::NUM_RAILS-1:0] SEQ_EN,
    input wire logic [3:0] RAIL_IN_REG,
    input wire logic [repg_pkg::NUM_RAILS-1:0] RAIL_EN,
    input wire logic [3:0] GP_OUT
);
    // ****
    // cycles that gp_output_3's rail has been good
    // ****
    logic [19:0] good3_q;
    logic [19:0] good3_d;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    always_comb begin
        good3_d = RAIL_IN_REG[2] ? good3_q + 20'h1 : 20'h0;
    end
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) good3_q <= 20'h0;
        else good3_q <= good3_d;
    end
    AST_ACK_AFTER_REQ: assert property ((REG_WR || REG_RD) |=> REG_ACK)
        else $error("ack missing");
    AST_NO_LONE_ACK: assert property (!(REG_WR || REG_RD) |=> !REG_ACK)
        else $error("ack without request");
    AST_UNMAPPED_ZERO: assert property ((REG_RD && !(REG_ADDR inside {8'h9d, 8'h9f, 8'ha0})) |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_RSVD_ZERO: assert property ((REG_RD && REG_ADDR == 8'h9f) |=> REG_RDATA[3:0] == 4'h0)
        else $error("reserved bits set");
    AST_STEP_OFF: assert property ((RAIL_EN[2:0] & ~$past(STEP_DIS)) == 3'h0)
        else $error("disabled step-down on");
    AST_SEQ_FOLLOW: assert property (1'b1 |=> (~RAIL_EN[5:3] & $past(SEQ_EN[5:3])) == 3'h0)
        else $error("rail ignores sequencing");
    AST_PG_DROP: assert property (##2 (GP_OUT & DLY_MASK & ~$past(RAIL_IN_REG, 2)) == 4'h0)
        else $error("power good held");
    AST_GP3_DELAY: assert property ((DLY_MASK[2] && $rose(GP_OUT[2])) |-> good3_q >= (GP3_DELAY_TICKS - 1) * TICK_CYCLES)
        else $error("gp_output_3 early");
    // worst tick phase plus two register stages bounds the late side
    AST_GP3_LATE: assert property ((DLY_MASK[2] && good3_q == 20'(GP3_DELAY_TICKS * TICK_CYCLES + 2)) |-> GP_OUT[2])
        else $error("gp_output_3 late");
endmodule : repg_props
bind repg_top repg_props #(.GP3_DELAY_TICKS(GP3_DELAY_TICKS), .TICK_CYCLES(TICK_CYCLES),
    .DLY_MASK({GP4_MODE == repg_pkg::GPO_DELAYED_PG, GP3_MODE == repg_pkg::GPO_DELAYED_PG,
    GP2_MODE == repg_pkg::GPO_DELAYED_PG, GP1_MODE == repg_pkg::GPO_DELAYED_PG})) u_props (.REF_CLK(REF_CLK), .RST(RST),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
    .STEP_DIS(STEP_DIS), .SEQ_EN(SEQ_EN), .RAIL_IN_REG(RAIL_IN_REG), .RAIL_EN(RAIL_EN), .GP_OUT(GP_OUT));
`default_nettype wire

// *** verif/repg_host_model.sv ***
// Purpose: host side of the register port
// Assumes: one-cycle strobe, answer next cycle
// Notes: address and data scrambled when idle
`timescale 1ns/10ps
`default_nettype none
module repg_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    // ****
    // single-byte access
    // ****
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        wr = w;
        rd = !w;
        addr = a;
        wdata = (a == 8'h9f) ? (d & 8'hf0) : d;
        @(posedge clk);
        #1;
        wr = 1'b0;
        rd = 1'b0;
        // idle bus must not look like the last request
        addr = ~a;
        wdata = ~wdata;
        q = rdata;
    endtask : access
endmodule : repg_host_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for repg_top
// Assumes: 100 MHz clock, default parameters except TICK_CYCLES and the gp modes of uut_modes
// Notes: delays measured in clock edges
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ****
    // stimulus and checks
    // ****
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, reg_ack;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q, frc, dis;
    logic [2:0] step_dis = 3'h7;
    logic [11:0] seq_en = 12'h000;
    logic [11:0] rail_en;
    logic [3:0] in_reg = 4'h0;
    logic [3:0] gp_out;
    logic [3:0] gp_lvl = 4'h0;
    logic [3:0] gp_ls = 4'h0;
    logic [3:0] gp_out_m;
    logic [11:0] rail_en_m;
    logic [7:0] regs [4] = '{8'h9d, 8'h9f, 8'ha0, 8'h9e};
    logic [7:0] defs [4] = '{8'h12, 8'hf0, 8'h00, 8'h00};
    integer seed = 32'h6fb56b3e;
    integer n_errors = 0;
    integer comparisons = 0;
    int rise [4];
    always #5 ref_clk = ~ref_clk;
    // short timebase keeps the longest delay code inside the run budget; delays scale with it
    localparam int TICK = 10;
    repg_top #(.TICK_CYCLES(TICK)) uut (.REF_CLK(ref_clk), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .STEP_DIS(step_dis),
        .SEQ_EN(seq_en), .RAIL_IN_REG(in_reg), .GP_LEVEL(gp_lvl), .GP_LS_IN(gp_ls), .RAIL_EN(rail_en),
        .GP_OUT(gp_out));
    // second build with the factory alternatives on gp outputs 1 to 3
    repg_top #(.TICK_CYCLES(TICK), .GP1_MODE(repg_pkg::GPO_SYSTEM_PG), .GP2_MODE(repg_pkg::GPO_LEVEL_SHIFT),
        .GP3_MODE(repg_pkg::GPO_SOFTWARE)) uut_modes (.REF_CLK(ref_clk), .RST(rst), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(), .REG_ACK(),
        .STEP_DIS(step_dis), .SEQ_EN(seq_en), .RAIL_IN_REG(in_reg), .GP_LEVEL(gp_lvl), .GP_LS_IN(gp_ls),
        .RAIL_EN(rail_en_m), .GP_OUT(gp_out_m));
    repg_host_model host (.clk(ref_clk), .rdata(reg_rdata), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr),
        .wdata(reg_wdata));
    function automatic logic [11:0] exp_en(logic [7:0] f, logic [7:0] d, logic [2:0] s, logic [11:0] sq);
        logic [11:0] allow;
        allow = {1'b1, d[4], d[7], d[6], 1'b1, d[5], 3'h7, s};
        return allow & ({4'h0, f} | sq);
    endfunction : exp_en
    function automatic int ticks(logic [2:0] c);
        int t [8] = '{25, 50, 100, 150, 200, 500, 500, 1000};
        return t[c];
    endfunction : ticks
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic meas(input logic [7:0] code, input bit glitch);
        int t [4];
        host.access(1'b1, 8'h9d, code, q);
        in_reg = 4'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        in_reg = 4'hf;
        if (glitch) begin
            // drop lands before the shortest nonzero delay ends, so the count must restart
            repeat (15 * TICK) @(posedge ref_clk);
            #1;
            in_reg = 4'h0;
            @(posedge ref_clk);
            #1;
            in_reg = 4'hf;
        end
        rise = '{99999, 99999, 99999, 99999};
        for (int i = 0; i < 12000 && gp_out != 4'hf; i++) begin
            @(posedge ref_clk);
            #1;
            foreach (rise[k]) if (gp_out[k] && rise[k] > i) rise[k] = i + 1;
        end
        t[0] = code[1:0] == 2'h0 ? 0 : ticks({1'b0, code[1:0]});
        t[1] = ticks(code[7:5]);
        t[2] = 50;
        t[3] = ticks(code[4:2]);
        foreach (t[k]) chk(12'(rise[k] >= (t[k] - 1) * TICK && rise[k] <= t[k] * TICK + 5), 12'h1);
    endtask : meas
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        foreach (regs[k]) begin
            host.access(1'b0, regs[k], 8'h00, q);
            chk({4'h0, q}, {4'h0, defs[k]});
        end
        for (int n = 0; n < 24; n++) begin
            frc = n == 0 ? 8'hff : 8'($random(seed));
            dis = n == 0 ? 8'h00 : 8'($random(seed));
            step_dis = n == 0 ? 3'h0 : 3'($random(seed));
            seq_en = n == 0 ? 12'hfff : 12'($random(seed));
            in_reg = 4'($random(seed));
            gp_lvl = 4'($random(seed));
            gp_ls = 4'($random(seed));
            host.access(1'b1, 8'ha0, frc, q);
            host.access(1'b1, 8'h9f, dis, q);
            @(posedge ref_clk);
            #1;
            chk(rail_en, exp_en(frc, dis, step_dis, seq_en));
            chk(rail_en_m, exp_en(frc, dis, step_dis, seq_en));
            chk({9'h000, gp_out_m[2:0]}, {9'h000, gp_lvl[2], gp_ls[1], &in_reg});
            host.access(1'b0, 8'h9f, 8'h00, q);
            chk({4'h0, q}, {4'h0, dis & 8'hf0});
        end
        meas(8'h05, 1'b1);
        meas(8'h00, 1'b0);
        meas(8'hb8, 1'b0);
        meas(8'hff, 1'b0);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
